// ### verilog/wtm_consts.svh
`ifndef WTM_CONSTS_SVH
`define WTM_CONSTS_SVH
// register indices; byte address is four times the index
`define WTM_IDX_WTC      6'h32
`define WTM_IDX_AMC      6'h33
`define WTM_IDX_AMR      6'h34
`define WTM_IDX_AVG      6'h35
`define WTM_IDX_LAST     6'h36
`define WTM_IDX_STAT     6'h3c
`define WTM_IDX_MASK     6'h3d
`define WTM_REG_RST      8'h00
// wake_timer_control fields
`define WTM_WTC_RANGE    7
`define WTM_WTC_TO_HI    6
`define WTM_WTC_TO_LO    4
`define WTM_WTC_WTO      3
`define WTM_WTC_WAM      2
`define WTM_WTC_WPH      1
`define WTM_WTC_WCAP     0
// amplitude_measure_config fields
`define WTM_AMC_DELTA_HI 7
`define WTM_AMC_DELTA_LO 4
`define WTM_AMC_INCL     3
`define WTM_AMC_WGT_HI   2
`define WTM_AMC_WGT_LO   1
`define WTM_AMC_REFSEL   0
// interrupt status and mask bits
`define WTM_IRQ_TMR      0
`define WTM_IRQ_AMP      1
`define WTM_IRQ_PH       2
`define WTM_IRQ_CAP      3
// timing
`define WTM_CLK_HZ       40000000
`define WTM_SHORT_MS     10
`define WTM_LONG_MS      100
// bus answers
`define WTM_RESP_OKAY    2'b00
`define WTM_RESP_SLVERR  2'b10
`endif

// ### verilog/wtm_pkg.sv
package wtm_pkg;

  typedef enum logic [0:0] {
    WTM_IDLE = 1'b0,
    WTM_WAIT = 1'b1
  } wtm_state_t;

  typedef struct packed {
    logic amp;
    logic phase;
    logic cap;
  } wtm_meas_req_t;

  typedef struct packed {
    logic [7:0] amp_val;
    logic       phase_over;
    logic       cap_over;
  } wtm_meas_res_t;

endpackage : wtm_pkg

// ### verilog/wtm_tick_gen.sv
`timescale 1ns/1ps
module wtm_tick_gen #(
  parameter int unsigned PERIOD = 400000
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic run,
  output logic      tick
);
  localparam int unsigned CW = $clog2(PERIOD);

  if (PERIOD < 2)
  begin : g_bad_period
    $error("wtm_tick_gen: PERIOD must be at least 2");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          tick_reg;
  logic          tick_next;

  // stopped timer restarts from a full period when enabled again
  always_comb
  begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run)
      cnt_next = '0;
    else if (cnt_reg == CW'(PERIOD - 1))
    begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end
    else
      cnt_next = cnt_reg + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule : wtm_tick_gen

// ### verilog/wtm_auto_avg.sv
`timescale 1ns/1ps
module wtm_auto_avg #(
  parameter int unsigned W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         upd,
  input  wire logic [W-1:0] sample,
  input  wire logic [1:0]   weight,
  output logic      [W-1:0] avg
);
  if (W < 2)
  begin : g_bad_width
    $error("wtm_auto_avg: W must be at least 2");
  end

  logic        [W-1:0] avg_reg;
  logic        [W-1:0] avg_next;
  logic signed [W+1:0] diff;
  logic signed [W+1:0] step;
  logic signed [W+1:0] sum;

  // weight 4/8/16/32 is an arithmetic shift by 2..5; the result always
  // lies between old average and sample, so it never wraps
  always_comb
  begin
    diff     = $signed({2'b00, sample}) - $signed({2'b00, avg_reg});
    step     = diff >>> ({1'b0, weight} + 3'd2);
    sum      = $signed({2'b00, avg_reg}) + step;
    avg_next = upd ? sum[W-1:0] : avg_reg;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      avg_reg <= '0;
    else
      avg_reg <= avg_next;
  end

  assign avg = avg_reg;
endmodule : wtm_auto_avg

// ### verilog/wtm_wakeup_timer.sv
// Operation
// - range bit picks 100 ms or 10 ms
// - timeout is (field plus one) times base
// - timeout-interrupt bit sets timer status every expiry; irq only if its mask bit is set
// - amplitude measurement at expiry, compare delta
// - phase measurement at expiry, flag over delta
// - capacitance measurement at expiry, flag over delta
// - amplitude delta from config bits 7..4
// - include bit decides averaging of triggering sample
// - weight field selects 4, 8, 16, 32
// - reference select clear uses fixed reference
// - all control registers reset to zero
// - average and latest result readable
`timescale 1ns/1ps
`include "wtm_consts.svh"
module wtm_wakeup_timer #(
  parameter int unsigned BASE_CYCLES =
    `WTM_CLK_HZ / 1000 * `WTM_SHORT_MS
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [7:0]             s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output wtm_pkg::wtm_meas_req_t      meas_req,
  input  wire logic                   meas_done,
  input  wire wtm_pkg::wtm_meas_res_t meas_res,
  output logic                        irq
);
  localparam int unsigned RATIO = `WTM_LONG_MS / `WTM_SHORT_MS;

  // control and status registers
  logic [7:0] wtc_reg, wtc_next;
  logic [7:0] amc_reg, amc_next;
  logic [7:0] amr_reg, amr_next;
  logic [7:0] last_reg, last_next;
  logic [3:0] stat_reg, stat_next;
  logic [3:0] mask_reg, mask_next;
  // bus slave state
  logic       aw_hold_reg, aw_hold_next;
  logic [5:0] aw_idx_reg, aw_idx_next;
  logic       w_hold_reg, w_hold_next;
  logic [7:0] w_data_reg, w_data_next;
  logic       w_en_reg, w_en_next;
  logic       bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic       rvalid_reg, rvalid_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // timer and sequencer
  logic [6:0]             tcnt_reg, tcnt_next;
  wtm_pkg::wtm_state_t    st_reg, st_next;
  wtm_pkg::wtm_meas_req_t pend_reg, pend_next;
  wtm_pkg::wtm_meas_req_t req_reg, req_next;

  logic       tick;
  logic       timer_on;
  logic [6:0] target;
  logic       expire;
  logic [7:0] avg;
  logic [7:0] amp_ref;
  logic [7:0] amp_diff;
  logic       amp_over;
  logic       amp_done;
  logic       avg_upd;
  logic [3:0] ev_set;
  logic       do_write;
  logic       wr_mapped;
  logic       rd_mapped;
  logic [3:0] w1c;

  // timer runs while any periodic function is enabled
  assign timer_on = |wtc_reg[`WTM_WTC_WTO:`WTM_WTC_WCAP];

  wtm_tick_gen #(
    .PERIOD (BASE_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .run     (timer_on),
    .tick    (tick)
  );

  assign target = 7'(({4'h0, wtc_reg[`WTM_WTC_TO_HI:`WTM_WTC_TO_LO]}
                      + 7'd1)
                     * (wtc_reg[`WTM_WTC_RANGE] ? 7'd1 : 7'(RATIO)));
  // comparing with >= keeps a shortened timeout from running 128 ticks
  assign expire = tick && ({1'b0, tcnt_reg} + 8'd1 >= {1'b0, target});

  always_comb
  begin
    tcnt_next = tcnt_reg;
    if (!timer_on || expire)
      tcnt_next = '0;
    else if (tick)
      tcnt_next = tcnt_reg + 7'd1;
  end

  assign amp_ref  = amc_reg[`WTM_AMC_REFSEL] ? avg : amr_reg;
  assign amp_diff = (meas_res.amp_val >= amp_ref)
                    ? meas_res.amp_val - amp_ref
                    : amp_ref - meas_res.amp_val;
  assign amp_over = amp_diff >
                    {4'h0, amc_reg[`WTM_AMC_DELTA_HI:`WTM_AMC_DELTA_LO]};
  assign amp_done = meas_done && (st_reg == wtm_pkg::WTM_WAIT)
                    && pend_reg.amp;
  assign avg_upd  = amp_done && (!amp_over || amc_reg[`WTM_AMC_INCL]);

  wtm_auto_avg #(
    .W (8)
  ) u_avg (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .upd     (avg_upd),
    .sample  (meas_res.amp_val),
    .weight  (amc_reg[`WTM_AMC_WGT_HI:`WTM_AMC_WGT_LO]),
    .avg     (avg)
  );

  // expiry during a running measurement still counts for the timer irq,
  // but no second measurement is started
  always_comb
  begin
    st_next   = st_reg;
    pend_next = pend_reg;
    req_next  = '0;
    last_next = last_reg;
    ev_set    = '0;
    ev_set[`WTM_IRQ_TMR] = expire && wtc_reg[`WTM_WTC_WTO];
    case (st_reg)
      wtm_pkg::WTM_IDLE:
      begin
        if (expire && |wtc_reg[`WTM_WTC_WAM:`WTM_WTC_WCAP])
        begin
          req_next.amp   = wtc_reg[`WTM_WTC_WAM];
          req_next.phase = wtc_reg[`WTM_WTC_WPH];
          req_next.cap   = wtc_reg[`WTM_WTC_WCAP];
          pend_next      = req_next;
          st_next        = wtm_pkg::WTM_WAIT;
        end
      end
      wtm_pkg::WTM_WAIT:
      begin
        if (meas_done)
        begin
          ev_set[`WTM_IRQ_AMP] = pend_reg.amp && amp_over;
          ev_set[`WTM_IRQ_PH]  = pend_reg.phase && meas_res.phase_over;
          ev_set[`WTM_IRQ_CAP] = pend_reg.cap && meas_res.cap_over;
          if (pend_reg.amp)
            last_next = meas_res.amp_val;
          pend_next = '0;
          st_next   = wtm_pkg::WTM_IDLE;
        end
      end
      default:
      begin
        pend_next = '0;
        st_next   = wtm_pkg::WTM_IDLE;
      end
    endcase
  end

  // write side: address and data taken in either order
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign do_write      = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_mapped     = (aw_idx_reg == `WTM_IDX_WTC)
                         || (aw_idx_reg == `WTM_IDX_AMC)
                         || (aw_idx_reg == `WTM_IDX_AMR)
                         || (aw_idx_reg == `WTM_IDX_STAT)
                         || (aw_idx_reg == `WTM_IDX_MASK);
  assign w1c = (do_write && w_en_reg && aw_idx_reg == `WTM_IDX_STAT)
               ? w_data_reg[3:0] : 4'h0;

  always_comb
  begin
    aw_hold_next = aw_hold_reg;
    aw_idx_next  = aw_idx_reg;
    w_hold_next  = w_hold_reg;
    w_data_next  = w_data_reg;
    w_en_next    = w_en_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    wtc_next     = wtc_reg;
    amc_next     = amc_reg;
    amr_next     = amr_reg;
    mask_next    = mask_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_next = 1'b1;
      aw_idx_next  = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata[7:0];
      w_en_next   = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_mapped ? `WTM_RESP_OKAY : `WTM_RESP_SLVERR;
      if (w_en_reg)
      begin
        case (aw_idx_reg)
          `WTM_IDX_WTC:  wtc_next  = w_data_reg;
          `WTM_IDX_AMC:  amc_next  = w_data_reg;
          `WTM_IDX_AMR:  amr_next  = w_data_reg;
          `WTM_IDX_MASK: mask_next = w_data_reg[3:0];
          default:       mask_next = mask_reg;
        endcase
      end
    end
    else if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
  end

  // set wins over a write-one-to-clear in the same cycle
  assign stat_next = (stat_reg & ~w1c) | ev_set;

  // read side
  assign s_axi_arready = !rvalid_reg;
  assign rd_mapped     = (s_axi_araddr[7:2] == `WTM_IDX_WTC)
                         || (s_axi_araddr[7:2] == `WTM_IDX_AMC)
                         || (s_axi_araddr[7:2] == `WTM_IDX_AMR)
                         || (s_axi_araddr[7:2] == `WTM_IDX_AVG)
                         || (s_axi_araddr[7:2] == `WTM_IDX_LAST)
                         || (s_axi_araddr[7:2] == `WTM_IDX_STAT)
                         || (s_axi_araddr[7:2] == `WTM_IDX_MASK);

  always_comb
  begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next  = rd_mapped ? `WTM_RESP_OKAY : `WTM_RESP_SLVERR;
      case (s_axi_araddr[7:2])
        `WTM_IDX_WTC:  rdata_next = wtc_reg;
        `WTM_IDX_AMC:  rdata_next = amc_reg;
        `WTM_IDX_AMR:  rdata_next = amr_reg;
        `WTM_IDX_AVG:  rdata_next = avg;
        `WTM_IDX_LAST: rdata_next = last_reg;
        `WTM_IDX_STAT: rdata_next = {4'h0, stat_reg};
        `WTM_IDX_MASK: rdata_next = {4'h0, mask_reg};
        default:       rdata_next = 8'h00;
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wtc_reg     <= `WTM_REG_RST;
      amc_reg     <= `WTM_REG_RST;
      amr_reg     <= `WTM_REG_RST;
      last_reg    <= 8'h00;
      stat_reg    <= 4'h0;
      mask_reg    <= 4'h0;
      aw_hold_reg <= 1'b0;
      aw_idx_reg  <= 6'h00;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_en_reg    <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 8'h00;
      rresp_reg   <= 2'h0;
      tcnt_reg    <= 7'h00;
      st_reg      <= wtm_pkg::WTM_IDLE;
      pend_reg    <= '0;
      req_reg     <= '0;
    end
    else
    begin
      wtc_reg     <= wtc_next;
      amc_reg     <= amc_next;
      amr_reg     <= amr_next;
      last_reg    <= last_next;
      stat_reg    <= stat_next;
      mask_reg    <= mask_next;
      aw_hold_reg <= aw_hold_next;
      aw_idx_reg  <= aw_idx_next;
      w_hold_reg  <= w_hold_next;
      w_data_reg  <= w_data_next;
      w_en_reg    <= w_en_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      tcnt_reg    <= tcnt_next;
      st_reg      <= st_next;
      pend_reg    <= pend_next;
      req_reg     <= req_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = {24'h000000, rdata_reg};
  assign s_axi_rresp  = rresp_reg;
  assign meas_req     = req_reg;
  assign irq          = |(stat_reg & mask_reg);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_tmr_irq;
    expire && wtc_reg[`WTM_WTC_WTO] |=> stat_reg[`WTM_IRQ_TMR];
  endproperty
  a_tmr_irq: assert property (p_tmr_irq)
    else $error("timer expiry did not set status");

  property p_restart;
    expire |=> tcnt_reg == 7'd0 ##1 tcnt_reg == 7'd0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("timer count did not restart");

  property p_amp_start;
    st_reg == wtm_pkg::WTM_IDLE && expire && wtc_reg[`WTM_WTC_WAM]
      |=> meas_req.amp ##1 !meas_req.amp;
  endproperty
  a_amp_start: assert property (p_amp_start)
    else $error("amplitude request not a single pulse");

  property p_ph_start;
    st_reg == wtm_pkg::WTM_IDLE && expire && wtc_reg[`WTM_WTC_WPH]
      |=> meas_req.phase && st_reg == wtm_pkg::WTM_WAIT;
  endproperty
  a_ph_start: assert property (p_ph_start)
    else $error("phase measurement not started");

  property p_cap_irq;
    st_reg == wtm_pkg::WTM_WAIT && meas_done && pend_reg.cap
      && meas_res.cap_over |=> stat_reg[`WTM_IRQ_CAP];
  endproperty
  a_cap_irq: assert property (p_cap_irq)
    else $error("capacitance over delta did not set status");

  property p_amp_irq_fixed;
    amp_done && !amc_reg[`WTM_AMC_REFSEL]
      && (meas_res.amp_val - amr_reg > {4'h0, amc_reg[7:4]})
      && meas_res.amp_val > amr_reg |=> stat_reg[`WTM_IRQ_AMP];
  endproperty
  a_amp_irq_fixed: assert property (p_amp_irq_fixed)
    else $error("amplitude over delta did not set status");

  property p_excl;
    amp_done && amp_over && !amc_reg[`WTM_AMC_INCL] |=> $stable(avg);
  endproperty
  a_excl: assert property (p_excl)
    else $error("excluded sample changed the average");

  property p_last;
    amp_done |=> last_reg == $past(meas_res.amp_val);
  endproperty
  a_last: assert property (p_last)
    else $error("latest result not captured");

  property p_no_meas_irq;
    st_reg == wtm_pkg::WTM_IDLE |=> !stat_reg[`WTM_IRQ_AMP]
      || $past(stat_reg[`WTM_IRQ_AMP]);
  endproperty
  a_no_meas_irq: assert property (p_no_meas_irq)
    else $error("amplitude status set without measurement");

  c_tmr: cover property (expire && wtc_reg[`WTM_WTC_WTO]);
  c_amp: cover property (amp_done && amp_over);
  c_avg: cover property (avg_upd && amc_reg[`WTM_AMC_REFSEL]);
  c_irq: cover property (irq && do_write);
endmodule : wtm_wakeup_timer

// ### bench/tb.sv
`timescale 1ns/1ps
`include "wtm_consts.svh"
module tb;
  localparam logic [7:0] A_WTC  = {`WTM_IDX_WTC, 2'b00};
  localparam logic [7:0] A_AMC  = {`WTM_IDX_AMC, 2'b00};
  localparam logic [7:0] A_REF  = {`WTM_IDX_AMR, 2'b00};
  localparam logic [7:0] A_AVG  = {`WTM_IDX_AVG, 2'b00};
  localparam logic [7:0] A_LAST = {`WTM_IDX_LAST, 2'b00};
  localparam logic [7:0] A_STAT = {`WTM_IDX_STAT, 2'b00};
  localparam logic [7:0] A_MASK = {`WTM_IDX_MASK, 2'b00};
  logic                   sys_clk, rstn;
  logic                   awvalid, awready, wvalid, wready;
  logic                   bvalid, bready, arvalid, arready;
  logic                   rvalid, rready, meas_done, irq;
  logic [7:0]             awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb;
  logic [1:0]             bresp, rresp;
  wtm_pkg::wtm_meas_req_t meas_req;
  wtm_pkg::wtm_meas_res_t meas_res;
  int                     err_count, cmp_count, cyc, expv;

  // short base tick keeps every timeout within 1600 cycles
  wtm_wakeup_timer #(.BASE_CYCLES(20)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .meas_req(meas_req), .meas_done(meas_done), .meas_res(meas_res),
    .irq(irq)
  );

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;
  // plain always: the reset initial also writes this counter
  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge sys_clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d;
    wstrb   <= 4'h1;
    while (!(ad && wd))
    begin
      @(posedge sys_clk);
      if (!ad && awready === 1'b1)
      begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1)
      begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge sys_clk);
    arvalid <= 1'b1;
    araddr  <= a;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", `WTM_RESP_OKAY, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk("rresp", `WTM_RESP_OKAY, r);
    chk($sformatf("reg %h", a), e, d);
  endtask : rd_chk

  // answers one batch; the front end inverts its result lines after
  task automatic measure(input logic [7:0] s, input logic ph, cp,
                         input logic [2:0] e);
    do @(posedge sys_clk); while (meas_req === 3'b000);
    chk("meas_req", e, meas_req);
    meas_done <= 1'b1;
    meas_res  <= '{amp_val: s, phase_over: ph, cap_over: cp};
    @(posedge sys_clk);
    meas_done <= 1'b0;
    meas_res  <= ~meas_res;
    repeat (2) @(posedge sys_clk);
  endtask : measure

  task automatic amp_case(input logic [7:0] s, input logic over);
    measure(s, 1'b0, 1'b0, 3'b100);
    rd_chk(A_LAST, s);
    rd_chk(A_STAT, over ? 32'h2 : 32'h0);
    wr(A_STAT, 32'h2);
  endtask : amp_case

  task automatic t_reset;
    logic [7:0]  al [7] = '{A_WTC, A_AMC, A_REF, A_AVG, A_LAST,
                            A_STAT, A_MASK};
    logic [31:0] d;
    logic [1:0]  r;
    foreach (al[i]) rd_chk(al[i], 32'h0);
    chk("irq", 1'b0, irq);
    axi_rd(8'h10, d, r);
    chk("unmapped rresp", `WTM_RESP_SLVERR, r);
    chk("unmapped rdata", 32'h0, d);
    axi_wr(8'h10, 32'h5a, r);
    chk("unmapped bresp", `WTM_RESP_SLVERR, r);
  endtask : t_reset

  task automatic t_average;
    wr(A_REF, 32'd200);
    wr(A_WTC, 32'hf4);
    expv = 0;
    for (int w = 0; w < 4; w++)
    begin
      wr(A_AMC, {24'h0, 4'hf, 1'b0, w[1:0], 1'b0});
      amp_case(8'd200, 1'b0);
      expv = expv + ((200 - expv) >>> (w + 2));
      rd_chk(A_AVG, expv);
    end
    wr(A_AMC, 32'h46);
    amp_case(8'd0, 1'b1);
    rd_chk(A_AVG, expv);
    wr(A_AMC, 32'h4e);
    amp_case(8'd0, 1'b1);
    expv = expv + ((0 - expv) >>> 5);
    rd_chk(A_AVG, expv);
    wr(A_AMC, 32'h47);
    amp_case(expv[7:0] + 8'd4, 1'b0);
    amp_case(expv[7:0] + 8'd5, 1'b1);
    wr(A_WTC, 32'h0);
  endtask : t_average

  task automatic t_fixed_ref;
    logic [7:0] s [4] = '{8'd204, 8'd196, 8'd205, 8'd195};
    wr(A_REF, 32'd200);
    wr(A_AMC, 32'h40);
    wr(A_WTC, 32'hf4);
    foreach (s[i]) amp_case(s[i], i > 1);
    wr(A_WTC, 32'h0);
  endtask : t_fixed_ref

  task automatic t_phase_cap;
    wr(A_WTC, 32'hf3);
    measure(8'h00, 1'b1, 1'b0, 3'b011);
    rd_chk(A_STAT, 32'h4);
    wr(A_STAT, 32'h4);
    measure(8'h00, 1'b0, 1'b1, 3'b011);
    rd_chk(A_STAT, 32'h8);
    chk("irq masked", 1'b0, irq);
    wr(A_MASK, 32'h8);
    chk("irq unmasked", 1'b1, irq);
    wr(A_STAT, 32'h8);
    chk("irq cleared", 1'b0, irq);
    wr(A_WTC, 32'h0);
    wr(A_MASK, 32'h0);
  endtask : t_phase_cap

  // period measured between two interrupt rises, not from the write
  task automatic t_period;
    logic [7:0] cfg [3] = '{8'h08, 8'h98, 8'hf8};
    int         ex  [3] = '{200, 40, 160};
    int         t0;
    wr(A_MASK, 32'h1);
    foreach (cfg[i])
    begin
      wr(A_STAT, 32'h1);
      wr(A_WTC, cfg[i]);
      do @(posedge sys_clk); while (irq !== 1'b1);
      t0 = cyc;
      wr(A_STAT, 32'h1);
      do @(posedge sys_clk); while (irq !== 1'b1);
      chk("period", ex[i], cyc - t0);
      wr(A_WTC, 32'h0);
    end
    wr(A_STAT, 32'h1);
  endtask : t_period

  initial
  begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end

  initial
  begin
    rstn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; meas_done = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    meas_res = '0; cyc = 0; err_count = 0; cmp_count = 0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_average();
    t_fixed_ref();
    t_phase_cap();
    t_period();
    give_verdict();
  end
endmodule : tb
